/* bfs_fault_supervisor.sv */
/*
  Fault supervisor for a boost LED driver: latched and auto-restart fault
  handling, undervoltage deglitch, latch clearing, APB registers and an
  interrupt. Comparator indications arrive synchronous to clk.
*/
// Behaviour
// - Secondary switch current limit shuts down at once and latches off
// - Input overcurrent shuts down within 3 us and latches
// - Input overcurrent pulls the fault flag
// - Input overcurrent drops disconnect gate drive and stays latched off
// - Enable above rising thresholds; disable after over 50 us below fall
// - Primary limit detector may be masked during startup blanking
// - Primary limit truncates on-time only; flag, disconnect, sinks untouched
// - Secondary limit drops disconnect, sinks, boost; sets flag; 32k clear
// - Input sense trip drops boost, disconnect, sinks; latched flag, 32k clear
// - Secondary overvoltage latches boost, disconnect, sinks off, flag set, 32k clear
// - LED grounded at dim start halts start; disconnect on, no flag
// - Falling undervoltage event clears every latched fault
// - Enable high, dim low 32k clears latches; bias and clock stay
// - A fault still present after clearing trips the latch again
// - Fault flag low while latched, high once cleared
`timescale 1ns/1ps
`default_nettype none

module bfs_fault_supervisor
  import bfs_pkg::*;
#(
  parameter int unsigned CLEAR_CNT = CLEAR_CYCLES,
  parameter int unsigned UV_CNT    = UV_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        en,
  input  wire logic        dim,
  input  wire logic        cycle_start,
  input  wire bfs_sense_s  sense,
  output var  bfs_drive_s  drive,
  output var  logic        irq,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr
);

  // -----------------------------------------------------------------------
  // State
  // -----------------------------------------------------------------------
  typedef struct packed {
    bfs_state_e         st;
    logic [2:0]         latch;
    logic               trunc;
    logic [BLANK_W-1:0] blank_cnt;
    logic               ctrl_blank;
    logic [N_EV-1:0]    irq_stat;
    logic [N_EV-1:0]    irq_mask;
    logic [31:0]        prdata;
    logic               dim_d;
    bfs_drive_s         drive;
  } bfs_core_s;

  bfs_core_s s_reg;
  bfs_core_s s_next;

  logic uv_done;
  logic clear_done;
  logic sleep_done;

  function automatic logic addr_hit(input logic [11:0] a);
    addr_hit = (a == OFS_CTRL) || (a == OFS_STATUS) ||
               (a == OFS_IRQ_STAT) || (a == OFS_IRQ_MASK);
  endfunction : addr_hit

  // STATUS packs state, truncation, timers and latches into one word
  function automatic logic [31:0] read_word(
    input logic [11:0] a,
    input bfs_core_s   s,
    input logic        asleep,
    input logic        uv_off
  );
    logic [31:0] w;
    w = 32'h0;
    case (a)
      OFS_CTRL: begin
        w[0] = s.ctrl_blank;
      end
      OFS_STATUS: begin
        w[8:6] = s.st;
        w[5]   = s.trunc;
        w[4]   = asleep;
        w[3]   = uv_off;
        w[2:0] = s.latch;
      end
      OFS_IRQ_STAT: begin
        w[N_EV-1:0] = s.irq_stat;
      end
      OFS_IRQ_MASK: begin
        w[N_EV-1:0] = s.irq_mask;
      end
      default: begin
        w = 32'h0;
      end
    endcase
    read_word = w;
  endfunction : read_word

  // -----------------------------------------------------------------------
  // Timers
  // -----------------------------------------------------------------------
  bfs_hold_timer #(.CYCLES(UV_CNT)) u_uv_timer (
    .clk     (clk),
    .sys_rst (sys_rst),
    .cond    (sense.uv_below_fall),
    .done    (uv_done)
  );

  // Restarts as soon as enable and dim are both high again
  bfs_hold_timer #(.CYCLES(CLEAR_CNT)) u_clear_timer (
    .clk     (clk),
    .sys_rst (sys_rst),
    .cond    (!en || !dim),
    .done    (clear_done)
  );

  bfs_hold_timer #(.CYCLES(CLEAR_CNT)) u_sleep_timer (
    .clk     (clk),
    .sys_rst (sys_rst),
    .cond    (!en),
    .done    (sleep_done)
  );

  // -----------------------------------------------------------------------
  // Next state
  // -----------------------------------------------------------------------
  logic            wr_acc;
  logic            rd_setup;
  logic [2:0]      trip;
  logic            pri_eff;
  logic            dim_rise;
  logic            live;
  logic [N_EV-1:0] ev;
  logic [N_EV-1:0] w1c;

  always_comb begin
    s_next   = s_reg;
    wr_acc   = psel && penable && pwrite && addr_hit(paddr);
    rd_setup = psel && !penable && !pwrite;
    dim_rise = dim && !s_reg.dim_d;
    live     = (s_reg.st != ST_UV_OFF);
    ev       = '0;
    w1c      = '0;

    s_next.dim_d = dim;

    // Latched faults are watched in every live state
    trip[EV_IN_OCP]   = live && sense.in_ocp;
    trip[EV_SEC_ILIM] = live && sense.sec_ilim;
    trip[EV_SEC_OVP]  = live && sense.sec_ovp;

    // The clear timer never beats a fault that is still present
    if (clear_done) begin
      s_next.latch = '0;
    end
    s_next.latch = s_next.latch | trip;
    ev[2:0]      = trip & ~s_reg.latch;

    // Blanking hides the primary limit early in soft start
    pri_eff = sense.pri_ilim &&
              !(s_reg.ctrl_blank && s_reg.blank_cnt != '0);
    if (s_reg.blank_cnt != '0) begin
      s_next.blank_cnt = s_reg.blank_cnt - BLANK_W'(1);
    end

    // On-time truncated until the next switching cycle begins
    if (s_reg.st == ST_RUN && pri_eff) begin
      s_next.trunc = 1'b1;
      ev[EV_PRI_ILIM] = !s_reg.trunc;
    end else if (cycle_start) begin
      s_next.trunc = 1'b0;
    end

    case (s_reg.st)
      ST_UV_OFF: begin
        // Below the falling level the rising level cannot be met either
        if (sense.vin_above_rise && sense.sense_above_rise &&
            !sense.uv_below_fall) begin
          s_next.st = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (s_next.latch != '0) begin
          s_next.st = ST_LATCHED;
        end else if (en && dim_rise) begin
          if (sense.led_gnd_short != '0) begin
            s_next.st      = ST_SHORT_HOLD;
            ev[EV_LED_GND] = 1'b1;
          end else begin
            s_next.st        = ST_RUN;
            s_next.blank_cnt = BLANK_W'(BLANK_CYCLES);
          end
        end
      end
      ST_SHORT_HOLD: begin
        if (s_next.latch != '0) begin
          s_next.st = ST_LATCHED;
        end else if (!en || !dim) begin
          s_next.st = ST_IDLE;
        end else if (sense.led_gnd_short == '0) begin
          s_next.st        = ST_RUN;
          s_next.blank_cnt = BLANK_W'(BLANK_CYCLES);
        end
      end
      ST_RUN: begin
        if (s_next.latch != '0) begin
          s_next.st = ST_LATCHED;
        end else if (!en || !dim) begin
          s_next.st = ST_IDLE;
        end
      end
      ST_LATCHED: begin
        if (s_next.latch == '0) begin
          s_next.st = ST_IDLE;
        end
      end
      default: begin
        s_next.st = ST_UV_OFF;
      end
    endcase

    // Deglitched undervoltage overrides everything
    if (live && uv_done) begin
      s_next.st     = ST_UV_OFF;
      s_next.latch  = '0;
      ev[EV_UV_OFF] = 1'b1;
    end

    // Outputs from the next state: one clock, far inside the 3 us budget
    s_next.drive.boost_on      = (s_next.st == ST_RUN) &&
                                 !s_next.trunc;
    s_next.drive.disconnect_on = en && (s_next.latch == '0) &&
      (s_next.st inside {ST_IDLE, ST_SHORT_HOLD, ST_RUN});
    s_next.drive.sink_en       = (s_next.st == ST_RUN) ?
                                 '1 : '0;
    s_next.drive.fault_n       = (s_next.latch == '0);
    // En high keeps bias up at once, before the sleep timer has fallen
    s_next.drive.bias_on       = !(sleep_done && !en);
    s_next.drive.clock_output_on = !(sleep_done && !en);

    // ---------------------------------------------------------------------
    // Register writes
    // ---------------------------------------------------------------------
    if (wr_acc && paddr == OFS_CTRL) begin
      s_next.ctrl_blank = pwdata[0];
    end
    if (wr_acc && paddr == OFS_IRQ_MASK) begin
      s_next.irq_mask = pwdata[N_EV-1:0];
    end
    if (wr_acc && paddr == OFS_IRQ_STAT) begin
      w1c = pwdata[N_EV-1:0];
    end
    // New events win over a simultaneous write-one-to-clear
    s_next.irq_stat = (s_reg.irq_stat & ~w1c) | ev;

    // Read data captured in the setup cycle
    if (rd_setup) begin
      s_next.prdata = read_word(paddr, s_reg, sleep_done, uv_done);
    end
  end

  // -----------------------------------------------------------------------
  // State register
  // -----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_reg            <= '0;
      s_reg.st         <= ST_UV_OFF;
      s_reg.ctrl_blank <= RST_CTRL_BLANK;
      s_reg.irq_mask   <= RST_IRQ_MASK;
      s_reg.drive.fault_n         <= 1'b1;
      s_reg.drive.bias_on         <= 1'b1;
      s_reg.drive.clock_output_on <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // -----------------------------------------------------------------------
  // Outputs
  // -----------------------------------------------------------------------
  assign drive   = s_reg.drive;
  assign irq     = |(s_reg.irq_stat & s_reg.irq_mask);
  assign prdata  = s_reg.prdata;
  // Zero wait states keep the slave simple; every access ends in one cycle
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !addr_hit(paddr);

endmodule : bfs_fault_supervisor

`default_nettype wire

/* bfs_fault_supervisor_monitor.sv */
/* Port checker for the fault supervisor.
   Assumes bind onto bfs_fault_supervisor, one clock, sync reset. */
`timescale 1ns/1ps
`default_nettype none
module bfs_fault_supervisor_monitor
  import bfs_pkg::*;
#(
  parameter int unsigned CLEAR_CNT = CLEAR_CYCLES,
  parameter int unsigned UV_CNT    = UV_CYCLES
) (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        en,
  input wire logic        dim,
  input wire logic        cycle_start,
  input wire bfs_sense_s  sense,
  input wire bfs_drive_s  drive,
  input wire logic        irq,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ----
  // Run lengths; four cycles past each count allowed for the registered timers
  // ----
  logic [15:0] clr_reg;
  logic [15:0] uv_reg;
  logic        lat;
  logic        on;
  assign lat = sense.in_ocp | sense.sec_ilim | sense.sec_ovp;
  assign on  = drive.boost_on | drive.disconnect_on;
  always_ff @(posedge clk) begin
    if (sys_rst || !en || dim || lat || sense.uv_below_fall) begin
      clr_reg <= '0;
    end else if (clr_reg != 16'hffff) begin
      clr_reg <= clr_reg + 16'h1;
    end
    if (sys_rst || !sense.uv_below_fall) begin
      uv_reg <= '0;
    end else if (uv_reg != 16'hffff) begin
      uv_reg <= uv_reg + 16'h1;
    end
  end
  a_latch_off:
  assert property (lat && on && !sense.uv_below_fall |=> !drive.boost_on
    && !drive.disconnect_on && drive.sink_en == '0) else $error("no off");
  a_latch_flag:
  assert property (lat && on && !sense.uv_below_fall &&
    !$past(sense.uv_below_fall) |=> !drive.fault_n)
    else $error("flag not set");
  a_flag_holds:
  assert property (!drive.fault_n && en && dim && $past(en && dim) &&
    !sense.uv_below_fall && !$past(sense.uv_below_fall) |=> !drive.fault_n)
    else $error("flag dropped");
  a_clear_done:
  assert property (clr_reg >= CLEAR_CNT + 4 |-> drive.fault_n)
    else $error("latch not cleared");
  a_uv_off:
  assert property (uv_reg >= UV_CNT + 4 |-> drive.fault_n && !on)
    else $error("undervoltage not off");
  a_bias_kept:
  assert property (en && $past(en) |-> drive.bias_on && drive.clock_output_on)
    else $error("bias dropped");
  a_sink_run:
  assert property (drive.sink_en != '0 |-> drive.fault_n && drive.disconnect_on)
    else $error("sinks on outside run");
  a_pri_keep:
  assert property (sense.pri_ilim && !lat && !sense.uv_below_fall && en && dim
    && drive.sink_en == '1 |=> drive.fault_n && drive.sink_en == '1 &&
    drive.disconnect_on) else $error("primary limit upset run");
endmodule : bfs_fault_supervisor_monitor
bind bfs_fault_supervisor bfs_fault_supervisor_monitor #(
  .CLEAR_CNT(CLEAR_CNT), .UV_CNT(UV_CNT)) i_bfs_mon (.clk(clk),
  .sys_rst(sys_rst), .en(en), .dim(dim), .cycle_start(cycle_start),
  .sense(sense), .drive(drive), .irq(irq), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr));
`default_nettype wire

/* bfs_fault_supervisor_tb.sv */
/* Testbench for the fault supervisor with stage model.
   Assumes short clear and deglitch counts set below. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin \
  n_mismatch++; $display("wrong value %s exp %h got %h", n, e, g); end end
module bfs_fault_supervisor_tb;
  import bfs_pkg::*;
  localparam int unsigned CC = 16;
  localparam int unsigned UC = 8;
  logic        clk, sys_rst, en, dim, cycle_start, irq, psel, penable;
  logic        pwrite, pready, pslverr, vin_low, vin_ok, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [3:0]  flt, shrt;
  bfs_sense_s  sense;
  bfs_drive_s  drv;
  int          n_mismatch = 0;
  int          tests_run = 0;
  int          cyc = 0;
  wire  [5:0]  pwr = {drv.boost_on, drv.disconnect_on, drv.sink_en};
  bfs_fault_supervisor #(.CLEAR_CNT(CC), .UV_CNT(UC)) i_bfs_fault_supervisor (
    .clk(clk), .sys_rst(sys_rst), .en(en), .dim(dim),
    .cycle_start(cycle_start), .sense(sense), .drive(drv), .irq(irq),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  bfs_stage_model i_bfs_stage_model (.flt(flt), .shrt(shrt),
    .vin_low(vin_low), .vin_ok(vin_ok), .drive(drv), .sense(sense));
  always #10 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt
  task automatic apb(input logic w, input logic [11:0] a, input int d);
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= 32'(d);
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic endt(input string s);
    $display("test %s done", s);
  endtask : endt
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish
  // ----
  // Main sequence
  // ----
  initial begin
    {clk, en, dim, cycle_start, psel, penable, pwrite, vin_low, vin_ok,
     paddr, pwdata, flt, shrt} = '0;
    sys_rst = 1'b1;
    wt(8);
    sys_rst <= 1'b0;
    apb(0, OFS_CTRL, 0);
    `CHK("blank", 1'b1, q[0])
    apb(0, OFS_IRQ_MASK, 0);
    `CHK("mask", 32'h0, q)
    apb(0, 12'h040, 0);
    `CHK("unmapped", 32'h0, q)
    `CHK("slverr", 1'b1, err)
    `CHK("pready", 1'b1, pready)
    // Blanking off so the primary limit acts at once
    apb(1, OFS_CTRL, 0);
    apb(0, OFS_STATUS, 0);
    `CHK("state", 3'h0, q[8:6])
    `CHK("fault_n", 1'b1, drv.fault_n)
    endt("reset");
    vin_ok <= 1'b1;
    en <= 1'b1;
    wt(3);
    dim <= 1'b1;
    wt(3);
    @(negedge clk);
    `CHK("run", 6'h3f, pwr)
    wt(1);
    flt <= 4'h8;
    wt(2);
    flt <= 4'h0;
    @(negedge clk);
    `CHK("trunc", 6'h1f, pwr)
    `CHK("fault_n", 1'b1, drv.fault_n)
    wt(1);
    cycle_start <= 1'b1;
    wt(1);
    cycle_start <= 1'b0;
    wt(2);
    @(negedge clk);
    `CHK("resume", 6'h3f, pwr)
    apb(0, OFS_IRQ_STAT, 0);
    `CHK("trunc ev", 1'b1, q[3])
    apb(1, OFS_IRQ_STAT, 32'h3f);
    endt("primary");
    for (int k = 0; k < 3; k++) begin
      wt(1);
      flt <= 4'h1 << k;
      wt(1);
      flt <= 4'h0;
      @(negedge clk);
      `CHK("fault_n", 1'b0, drv.fault_n)
      `CHK("off", 6'h00, pwr)
      apb(0, OFS_STATUS, 0);
      `CHK("latch", 3'h1 << k, q[2:0])
      dim <= 1'b0;
      wt(2);
      dim <= 1'b1;
      wt(3);
      @(negedge clk);
      `CHK("held", 6'h00, pwr)
      wt(1);
      dim <= 1'b0;
      wt(CC + 6);
      @(negedge clk);
      `CHK("cleared", 1'b1, drv.fault_n)
      `CHK("bias", 2'h3, {drv.bias_on, drv.clock_output_on})
      wt(1);
      dim <= 1'b1;
      wt(3);
      @(negedge clk);
      `CHK("restart", 6'h3f, pwr)
    end
    endt("latched");
    apb(1, OFS_IRQ_MASK, 32'h8);
    @(negedge clk);
    `CHK("irq masked", 1'b0, irq)
    apb(1, OFS_IRQ_MASK, 32'h1);
    @(negedge clk);
    `CHK("irq", 1'b1, irq)
    apb(1, OFS_IRQ_STAT, 32'h3f);
    @(negedge clk);
    `CHK("irq clr", 1'b0, irq)
    endt("irq");
    wt(1);
    flt <= 4'h1;
    wt(1);
    flt <= 4'h0;
    dim <= 1'b0;
    wt(CC - 2);
    dim <= 1'b1;
    wt(1);
    dim <= 1'b0;
    wt(CC - 2);
    @(negedge clk);
    `CHK("restarted", 1'b0, drv.fault_n)
    wt(1);
    flt <= 4'h1;
    wt(CC + 6);
    @(negedge clk);
    `CHK("retrip", 1'b0, drv.fault_n)
    wt(1);
    flt <= 4'h0;
    wt(CC + 6);
    @(negedge clk);
    `CHK("gone", 1'b1, drv.fault_n)
    endt("retrip");
    wt(1);
    shrt <= 4'h2;
    dim <= 1'b1;
    wt(3);
    @(negedge clk);
    `CHK("halt", 6'h10, pwr)
    `CHK("fault_n", 1'b1, drv.fault_n)
    wt(1);
    shrt <= 4'h0;
    wt(3);
    @(negedge clk);
    `CHK("proceed", 6'h3f, pwr)
    apb(0, OFS_IRQ_STAT, 0);
    `CHK("short ev", 1'b1, q[EV_LED_GND])
    endt("short");
    for (int g = 0; g < 2; g++) begin
      wt(1);
      vin_low <= 1'b1;
      wt(UC);
      vin_low <= 1'b0;
    end
    wt(2);
    @(negedge clk);
    `CHK("glitch", 6'h3f, pwr)
    wt(1);
    flt <= 4'h1;
    wt(1);
    flt <= 4'h0;
    vin_low <= 1'b1;
    wt(UC + 6);
    @(negedge clk);
    `CHK("uv flag", 1'b1, drv.fault_n)
    `CHK("uv off", 6'h00, pwr)
    apb(0, OFS_STATUS, 0);
    `CHK("uv state", 6'h00, {q[8:6], q[2:0]})
    apb(0, OFS_IRQ_STAT, 0);
    `CHK("uv ev", 1'b1, q[EV_UV_OFF])
    vin_low <= 1'b0;
    wt(3);
    apb(0, OFS_STATUS, 0);
    `CHK("idle", 3'h1, q[8:6])
    endt("undervoltage");
    apb(1, OFS_CTRL, 1);
    dim <= 1'b0;
    wt(2);
    dim <= 1'b1;
    flt <= 4'h8;
    wt(6);
    @(negedge clk);
    `CHK("blanked", 6'h3f, pwr)
    wt(1);
    flt <= 4'h0;
    endt("blanking");
    tally_and_finish();
  end
endmodule : bfs_fault_supervisor_tb
`default_nettype wire

/* bfs_hold_timer.sv */
/*
  Consecutive-cycle hold timer. Output goes high once the condition has
  been true for more than CYCLES clocks and falls with the condition.
  Assumes a synchronous, active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none

module bfs_hold_timer
  import bfs_pkg::*;
#(
  parameter int unsigned CYCLES = 16,
  parameter int unsigned W      = $clog2(CYCLES + 1)
) (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic cond,
  output var  logic done
);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         done;
  } bfs_timer_s;

  localparam logic [W-1:0] LIMIT = W'(CYCLES);

  bfs_timer_s st_reg;
  bfs_timer_s st_next;

  always_comb begin
    st_next = st_reg;
    if (!cond) begin
      st_next.cnt  = '0;
      st_next.done = 1'b0;
    end else if (st_reg.cnt == LIMIT) begin
      st_next.done = 1'b1;
    end else begin
      st_next.cnt = st_reg.cnt + W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign done = st_reg.done;

endmodule : bfs_hold_timer

`default_nettype wire

/* bfs_pkg.sv */
/*
  Shared constants, state enumeration and carrier structs for the boost LED
  fault supervisor. Assumes a single 50 MHz supervisory clock.
*/
`default_nettype none

package bfs_pkg;

  // ---------------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------------
  localparam int unsigned CLK_MHZ          = 50;
  localparam int unsigned UV_DEGLITCH_NS   = 50000;
  // Least time: rounded up to whole cycles
  localparam int unsigned UV_CYCLES        =
    (UV_DEGLITCH_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned SHUTDOWN_MAX_NS  = 3000;
  // Longest time: rounded down; the design shuts down in one cycle
  localparam int unsigned SHUTDOWN_MAX_CYC =
    (SHUTDOWN_MAX_NS * CLK_MHZ) / 1000;
  localparam int unsigned CLEAR_CYCLES     = 32768;
  localparam int unsigned BLANK_CYCLES     = 255;
  localparam int unsigned BLANK_W          = 8;
  localparam int unsigned N_SINKS          = 4;

  // ---------------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------------
  localparam logic [11:0] OFS_CTRL     = 12'h000;
  localparam logic [11:0] OFS_STATUS   = 12'h004;
  localparam logic [11:0] OFS_IRQ_STAT = 12'h008;
  localparam logic [11:0] OFS_IRQ_MASK = 12'h00c;

  localparam logic        RST_CTRL_BLANK = 1'b1;
  localparam logic [5:0]  RST_IRQ_MASK   = 6'h00;

  // Event / status bit positions
  localparam int unsigned EV_IN_OCP   = 0;
  localparam int unsigned EV_SEC_ILIM = 1;
  localparam int unsigned EV_SEC_OVP  = 2;
  localparam int unsigned EV_PRI_ILIM = 3;
  localparam int unsigned EV_LED_GND  = 4;
  localparam int unsigned EV_UV_OFF   = 5;
  localparam int unsigned N_EV        = 6;

  // ---------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_UV_OFF,
    ST_IDLE,
    ST_SHORT_HOLD,
    ST_RUN,
    ST_LATCHED
  } bfs_state_e;

  typedef struct packed {
    logic               in_ocp;
    logic               sec_ilim;
    logic               sec_ovp;
    logic               pri_ilim;
    logic [N_SINKS-1:0] led_gnd_short;
    logic               uv_below_fall;
    logic               vin_above_rise;
    logic               sense_above_rise;
  } bfs_sense_s;

  typedef struct packed {
    logic               boost_on;
    logic               disconnect_on;
    logic [N_SINKS-1:0] sink_en;
    logic               fault_n;
    logic               bias_on;
    logic               clock_output_on;
  } bfs_drive_s;

endpackage : bfs_pkg

`default_nettype wire

/* bfs_stage_model.sv */
/* Power stage comparator model.
   Assumes bench fault requests arrive just after clock edges. */
`timescale 1ns/1ps
`default_nettype none
module bfs_stage_model
  import bfs_pkg::*;
(
  input  wire logic [3:0] flt,
  input  wire logic [3:0] shrt,
  input  wire logic       vin_low,
  input  wire logic       vin_ok,
  input  wire bfs_drive_s drive,
  output var  bfs_sense_s sense
);
  always_comb begin
    sense                  = '0;
    // Shorted output keeps input current high regardless of switching
    sense.in_ocp           = flt[0];
    // Switch current and node voltage only exist while boost switches
    sense.sec_ilim         = flt[1] & drive.boost_on;
    sense.sec_ovp          = flt[2] & drive.boost_on;
    sense.pri_ilim         = flt[3] & drive.boost_on;
    sense.led_gnd_short    = shrt;
    sense.uv_below_fall    = vin_low;
    // Rising level lies above the falling one: both cannot hold at once
    sense.vin_above_rise   = vin_ok & ~vin_low;
    sense.sense_above_rise = vin_ok & ~vin_low;
  end
endmodule : bfs_stage_model
`default_nettype wire
